// *** core/mrs_crc16.sv ***
`timescale 1ns/1ps
`default_nettype none
module mrs_crc16
  import mrs_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  mrs_crc_if.engine crc_bus // Byte stream and running check value
);
  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  // Eight right shifts per byte, folding in the polynomial on a one
  always_comb begin
    crc_next = crc_reg ^ {8'h00, crc_bus.data};
    for (int i = 0; i < 8; i++) begin
      if (crc_next[0]) begin
        crc_next = (crc_next >> 1) ^ CRC_POLY;
      end else begin
        crc_next = crc_next >> 1;
      end
    end
  end

  // Restart wins over a byte update
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_reg <= CRC_INIT;
    end else if (crc_bus.init) begin
      crc_reg <= CRC_INIT;
    end else if (crc_bus.en) begin
      crc_reg <= crc_next;
    end
  end

  assign crc_bus.crc = crc_reg;
endmodule
`default_nettype wire

// *** core/mrs_crc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Byte stream into one check field engine
interface mrs_crc_if;
  logic init;
  logic en;
  logic [7:0] data;
  logic [15:0] crc;
  modport master(output init, output en, output data, input crc);
  modport engine(input init, input en, input data, output crc);
endinterface
`default_nettype wire

// *** core/mrs_pkg.sv ***
`default_nettype none
// Shared constants and types of the response decision block
package mrs_pkg;
  // Addressing
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  // Supported function codes
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  localparam logic [7:0] FN_DIAG = 8'h08;
  localparam logic [7:0] FN_MULTI = 8'h10;
  // Exception function flag and exception codes
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] EXC_SLAVE = 8'h04;
  // Internal communication error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_FUNC = 8'h88;
  localparam logic [7:0] ERR_UI = 8'h89;
  localparam logic [7:0] ERR_NV = 8'h8a;
  localparam logic [7:0] ERR_DATA = 8'h8c;
  localparam logic [7:0] ERR_DIS = 8'h8d;
  // Check field arithmetic
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  // Data address and quantity limits
  localparam logic [15:0] ADDR_MAX = 16'h1fff;
  localparam logic [16:0] ADDR_LIMIT = 17'h02000;
  localparam logic [15:0] MAX_REGS = 16'h0010;
  localparam logic [15:0] DIAG_SUB_ECHO = 16'h0000;
  // Frame lengths in bytes, check field included
  localparam logic [8:0] MAX_FRAME = 9'h100;
  localparam logic [8:0] MIN_FRAME = 9'h004;
  localparam logic [8:0] FIXED_LEN = 9'h008;
  localparam logic [8:0] MULTI_HDR = 9'h009;
  localparam logic [8:0] MULTI_MIN = 9'h00b;
  localparam logic [8:0] MULTI_MAX = 9'h029;
  // Header byte counts of the reply, minus one
  localparam logic [2:0] HDR_LAST_ECHO = 3'h5;
  localparam logic [2:0] HDR_LAST_SHORT = 3'h2;
  // Query bytes kept for decoding and echo
  localparam int QBYTES = 7;
  // Parity settings
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RX = 4'h1,
    ST_DECIDE = 4'h2,
    ST_EXEC = 4'h3,
    ST_HDR = 4'h4,
    ST_RDREQ = 4'h5,
    ST_HI = 4'h6,
    ST_LO = 4'h7,
    ST_CL = 4'h8,
    ST_CH = 4'h9
  } mrs_state_t;
endpackage
`default_nettype wire

// *** core/mrs_slave_resp.sv ***
`timescale 1ns/1ps
`default_nettype none
module mrs_slave_resp
  import mrs_pkg::*;
(
  input wire logic core_clk, // System clock, 10 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic rx_valid, // Received character strobe
  input wire logic [7:0] rx_data, // Received character
  input wire logic rx_parity_bit, // Sampled parity bit of the character
  input wire logic rx_stop_bit, // Sampled stop bit of the character
  input wire logic frame_end, // Silent interval seen, frame complete
  input wire logic [1:0] cfg_parity, // Parity setting: none, even, odd
  input wire logic [7:0] cfg_slave_addr, // Own slave address
  input wire logic ui_session_active, // User interface session running
  input wire logic nv_processing, // Nonvolatile memory work under way
  input wire logic internal_busy_flag, // Internal processing busy
  input wire logic nv_alarm, // Nonvolatile memory error alarm
  input wire logic cmd_exec_disable, // Command execution disabled
  output logic op_req, // Write execution request
  output logic [7:0] op_func, // Function of the write
  output logic [15:0] op_addr, // Start register address
  output logic [15:0] op_value, // Value or register count field
  output logic op_bcast, // Write came as broadcast
  input wire logic op_done, // Write execution finished
  input wire logic op_range_err, // Written value out of setting range
  output logic reg_rd_req, // Holding register read request
  output logic [15:0] reg_rd_addr, // Register address to read
  input wire logic reg_rd_ack, // Read data valid
  input wire logic [15:0] reg_rd_data, // Read register value
  output logic tx_valid, // Reply byte valid
  output logic [7:0] tx_data, // Reply byte
  input wire logic tx_ready, // Transmitter takes the byte
  output logic comm_err_valid, // Error code logged, one cycle
  output logic [7:0] comm_err_code // Last logged error code
);
  mrs_state_t state_reg;
  mrs_state_t state_next;
  logic [7:0] q_reg [QBYTES];
  logic [8:0] cnt_reg;
  logic err_frame_reg;
  logic err_par_reg;
  logic err_len_reg;
  logic [7:0] exc_reg;
  logic [2:0] idx_reg;
  logic [4:0] k_reg;
  logic [15:0] rd_addr_reg;
  logic [15:0] rd_word_reg;
  logic tx_ld_reg;
  logic [7:0] tx_data_reg;
  logic err_valid_reg;
  logic [7:0] err_code_reg;

  mrs_crc_if rx_crc();
  mrs_crc_if tx_crc();

  // Check engines for the received and the sent stream
  mrs_crc16 u_rx_crc (.core_clk(core_clk), .arst_n(arst_n), .crc_bus(rx_crc));
  mrs_crc16 u_tx_crc (.core_clk(core_clk), .arst_n(arst_n), .crc_bus(tx_crc));

  // Query field views
  logic [7:0] q_func;
  logic [15:0] q_start;
  logic [15:0] q_qty;
  logic [7:0] q_bcnt;
  logic [16:0] q_span;
  assign q_func = q_reg[1];
  assign q_start = {q_reg[2], q_reg[3]};
  assign q_qty = {q_reg[4], q_reg[5]};
  assign q_bcnt = q_reg[6];
  assign q_span = {1'b0, q_start} + {1'b0, q_qty};

  // Character acceptance and line checks
  logic rx_take;
  logic par_calc;
  logic par_bad;
  assign rx_take = rx_valid && (state_reg == ST_IDLE || state_reg == ST_RX);
  assign par_calc = (^rx_data) ^ rx_parity_bit;
  assign par_bad = (cfg_parity == PAR_EVEN && par_calc) || (cfg_parity == PAR_ODD && !par_calc);

  // Transmission and addressing decode
  logic xmit_err;
  logic is_bcast;
  logic addr_hit;
  logic is_write;
  logic drop;
  assign xmit_err = err_frame_reg || err_par_reg || err_len_reg
                    || (rx_crc.crc != CRC_RESIDUE) || (cnt_reg < MIN_FRAME);
  assign is_bcast = (q_reg[0] == BCAST_ADDR);
  assign addr_hit = (q_reg[0] == cfg_slave_addr) || is_bcast;
  assign is_write = (q_func == FN_WRITE) || (q_func == FN_MULTI);
  assign drop = xmit_err || !addr_hit || (is_bcast && !is_write);

  // Exception causes
  logic func_ok;
  logic exc_fn;
  logic len_ok;
  logic qty_bad;
  logic bcnt_bad;
  logic exc_data;
  logic exc_addr;
  logic exc_nv;
  logic exc_dis;
  assign func_ok = (q_func == FN_READ) || is_write || (q_func == FN_DIAG);
  assign exc_fn = !func_ok || (q_func == FN_DIAG && q_start != DIAG_SUB_ECHO);
  assign len_ok = (q_func == FN_MULTI)
                  ? (cnt_reg == MULTI_HDR + {1'b0, q_bcnt}) && (cnt_reg >= MULTI_MIN)
                    && (cnt_reg <= MULTI_MAX)
                  : (cnt_reg == FIXED_LEN);
  assign qty_bad = (q_func == FN_READ || q_func == FN_MULTI)
                   && (q_qty == 16'h0000 || q_qty > MAX_REGS);
  assign bcnt_bad = (q_func == FN_MULTI) && ({8'h00, q_bcnt} != {q_qty[14:0], 1'b0});
  assign exc_data = !len_ok || qty_bad || bcnt_bad;
  assign exc_addr = (q_start > ADDR_MAX)
                    || ((q_func == FN_READ || q_func == FN_MULTI) && q_span >= ADDR_LIMIT);
  assign exc_nv = nv_processing || internal_busy_flag || nv_alarm;
  assign exc_dis = cmd_exec_disable && is_write;

  // Priority of causes: function, data, address, slave state
  logic [7:0] sel_exc;
  logic [7:0] sel_err;
  assign sel_exc = exc_fn ? EXC_FUNC : exc_data ? EXC_DATA : exc_addr ? EXC_ADDR
                   : (ui_session_active || exc_nv || exc_dis) ? EXC_SLAVE : EXC_NONE;
  assign sel_err = exc_fn ? ERR_FUNC : exc_data ? ERR_DATA : exc_addr ? ERR_NONE
                   : ui_session_active ? ERR_UI : exc_nv ? ERR_NV
                   : exc_dis ? ERR_DIS : ERR_NONE;

  // Reply shaping
  logic tx_send;
  logic tx_acc;
  logic rd_reply;
  logic [2:0] hdr_last;
  logic [4:0] k_inc;
  logic last_word;
  logic [7:0] hdr_byte;
  logic [7:0] tx_byte;
  assign tx_send = (state_reg == ST_HDR) || (state_reg == ST_HI) || (state_reg == ST_LO)
                   || (state_reg == ST_CL) || (state_reg == ST_CH);
  assign tx_valid = tx_send && tx_ld_reg;
  assign tx_acc = tx_valid && tx_ready;
  assign rd_reply = (exc_reg == EXC_NONE) && (q_func == FN_READ);
  assign hdr_last = (exc_reg != EXC_NONE || q_func == FN_READ) ? HDR_LAST_SHORT
                    : HDR_LAST_ECHO;
  assign k_inc = k_reg + 5'h01;
  assign last_word = (k_inc == q_qty[4:0]);
  assign hdr_byte = (idx_reg == 3'h1 && exc_reg != EXC_NONE) ? (q_func | EXC_FLAG)
                    : (idx_reg == 3'h2 && exc_reg != EXC_NONE) ? exc_reg
                    : (idx_reg == 3'h2 && q_func == FN_READ) ? {q_qty[6:0], 1'b0}
                    : q_reg[idx_reg];
  assign tx_byte = (state_reg == ST_HDR) ? hdr_byte
                   : (state_reg == ST_HI) ? rd_word_reg[15:8]
                   : (state_reg == ST_LO) ? rd_word_reg[7:0]
                   : (state_reg == ST_CL) ? tx_crc.crc[7:0]
                   : tx_crc.crc[15:8];

  // Check engine feeds
  assign rx_crc.init = (state_reg == ST_DECIDE);
  assign rx_crc.en = rx_take;
  assign rx_crc.data = rx_data;
  assign tx_crc.init = (state_reg == ST_DECIDE);
  assign tx_crc.en = tx_acc && (state_reg != ST_CL) && (state_reg != ST_CH);
  assign tx_crc.data = tx_data_reg;

  // Outward requests and views
  assign op_req = (state_reg == ST_EXEC);
  assign op_func = q_func;
  assign op_addr = q_start;
  assign op_value = q_qty;
  assign op_bcast = is_bcast;
  assign reg_rd_req = (state_reg == ST_RDREQ);
  assign reg_rd_addr = rd_addr_reg;
  assign tx_data = tx_data_reg;
  assign comm_err_valid = err_valid_reg;
  assign comm_err_code = err_code_reg;

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (rx_take) state_next = ST_RX;
      end
      ST_RX: begin
        if (frame_end) state_next = ST_DECIDE;
      end
      ST_DECIDE: begin
        if (drop) begin
          state_next = ST_IDLE;
        end else if (sel_exc != EXC_NONE) begin
          state_next = is_bcast ? ST_IDLE : ST_HDR;
        end else if (is_write) begin
          state_next = ST_EXEC;
        end else begin
          state_next = ST_HDR;
        end
      end
      ST_EXEC: begin
        if (op_done) state_next = is_bcast ? ST_IDLE : ST_HDR;
      end
      ST_HDR: begin
        if (tx_acc && idx_reg == hdr_last) state_next = rd_reply ? ST_RDREQ : ST_CL;
      end
      ST_RDREQ: begin
        if (reg_rd_ack) state_next = ST_HI;
      end
      ST_HI: begin
        if (tx_acc) state_next = ST_LO;
      end
      ST_LO: begin
        if (tx_acc) state_next = last_word ? ST_CL : ST_RDREQ;
      end
      ST_CL: begin
        if (tx_acc) state_next = ST_CH;
      end
      ST_CH: begin
        if (tx_acc) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // Byte count and sticky line faults, cleared once a frame is judged
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 9'h000;
      err_frame_reg <= 1'b0;
      err_par_reg <= 1'b0;
      err_len_reg <= 1'b0;
    end else if (state_reg == ST_DECIDE) begin
      cnt_reg <= 9'h000;
      err_frame_reg <= 1'b0;
      err_par_reg <= 1'b0;
      err_len_reg <= 1'b0;
    end else if (rx_take) begin
      if (cnt_reg != MAX_FRAME) cnt_reg <= cnt_reg + 9'h001;
      if (cnt_reg == MAX_FRAME) err_len_reg <= 1'b1;
      if (!rx_stop_bit) err_frame_reg <= 1'b1;
      if (par_bad) err_par_reg <= 1'b1;
    end
  end

  // Leading query bytes for decode and echo
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < QBYTES; i++) q_reg[i] <= 8'h00;
    end else begin
      for (int i = 0; i < QBYTES; i++) begin
        if (rx_take && cnt_reg == 9'(i)) q_reg[i] <= rx_data;
      end
    end
  end

  // Exception code of the pending reply
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) exc_reg <= EXC_NONE;
    else if (state_reg == ST_DECIDE) exc_reg <= sel_exc;
    else if (state_reg == ST_EXEC && op_done && op_range_err) exc_reg <= EXC_SLAVE;
  end

  // Header index, word counter and ascending read address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_reg <= 3'h0;
      k_reg <= 5'h00;
      rd_addr_reg <= 16'h0000;
    end else if (state_reg == ST_DECIDE) begin
      idx_reg <= 3'h0;
      k_reg <= 5'h00;
      rd_addr_reg <= q_start;
    end else if (tx_acc && state_reg == ST_HDR) begin
      idx_reg <= (idx_reg == hdr_last) ? 3'h0 : idx_reg + 3'h1;
    end else if (tx_acc && state_reg == ST_LO) begin
      k_reg <= k_inc;
      rd_addr_reg <= rd_addr_reg + 16'h0001;
    end
  end

  // Register value held while its two bytes go out
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) rd_word_reg <= 16'h0000;
    else if (state_reg == ST_RDREQ && reg_rd_ack) rd_word_reg <= reg_rd_data;
  end

  // Output byte is loaded one cycle after each step, then held until taken
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ld_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else if (tx_acc) begin
      tx_ld_reg <= 1'b0;
    end else if (tx_send && !tx_ld_reg) begin
      tx_ld_reg <= 1'b1;
      tx_data_reg <= tx_byte;
    end
  end

  // Internal error code log
  logic err_log;
  logic [7:0] err_log_code;
  assign err_log = (state_reg == ST_DECIDE && !drop && sel_err != ERR_NONE)
                   || (state_reg == ST_EXEC && op_done && op_range_err);
  assign err_log_code = (state_reg == ST_EXEC) ? ERR_DATA : sel_err;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_valid_reg <= 1'b0;
      err_code_reg <= ERR_NONE;
    end else begin
      err_valid_reg <= err_log;
      if (err_log) err_code_reg <= err_log_code;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_judge;
    state_reg == ST_DECIDE && !xmit_err && addr_hit;
  endsequence
  sequence s_crc_pair;
    (state_reg == ST_CL && tx_acc) ##1 (state_reg == ST_CH);
  endsequence

  a_stop_bit_drop: assert property (
    state_reg == ST_DECIDE && err_frame_reg |=> state_reg == ST_IDLE ##1 !tx_valid[*8])
    else $error("frame with bad stop bit was answered");
  a_parity_drop: assert property (
    state_reg == ST_DECIDE && err_par_reg |=> state_reg == ST_IDLE)
    else $error("frame with parity fault was not dropped");
  a_crc_drop: assert property (
    state_reg == ST_DECIDE && rx_crc.crc != CRC_RESIDUE |=> state_reg == ST_IDLE)
    else $error("frame with check mismatch was not dropped");
  a_length_limit: assert property (
    rx_take && cnt_reg == MAX_FRAME |=> err_len_reg && cnt_reg == MAX_FRAME)
    else $error("overlong frame not flagged");
  a_bcast_silent: assert property (
    state_reg == ST_DECIDE && is_bcast |=> !tx_valid[*8])
    else $error("broadcast produced a reply");
  a_foreign_addr: assert property (
    state_reg == ST_DECIDE && !addr_hit |=> state_reg == ST_IDLE)
    else $error("query for another slave was not ignored");
  a_exc_function: assert property (
    state_reg == ST_HDR && idx_reg == 3'h1 && exc_reg != EXC_NONE && tx_valid
    |-> tx_data == (q_func | EXC_FLAG))
    else $error("exception function byte wrong");
  a_exc_length: assert property (
    state_reg == ST_HDR && exc_reg != EXC_NONE && tx_acc && idx_reg == HDR_LAST_SHORT
    |=> state_reg == ST_CL)
    else $error("exception frame has wrong length");
  a_bad_function: assert property (
    s_judge and !is_bcast && !func_ok |=> exc_reg == EXC_FUNC && comm_err_code == ERR_FUNC)
    else $error("unsupported function not reported");
  a_user_session: assert property (
    s_judge and !is_bcast && !exc_fn && !exc_data && !exc_addr && ui_session_active
    |=> exc_reg == EXC_SLAVE && comm_err_code == ERR_UI)
    else $error("user session busy not reported");
  a_read_ascend: assert property (
    state_reg == ST_LO && tx_acc && !last_word |=> reg_rd_req && reg_rd_addr == $past(reg_rd_addr) + 16'h0001)
    else $error("read addresses not ascending");
  a_check_order: assert property (
    s_crc_pair |=> tx_valid && tx_data == tx_crc.crc[15:8])
    else $error("check bytes out of order");
endmodule
`default_nettype wire

// *** testbench/mrs_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far side: register source, write executor and transmitter, all with random delays
module mrs_partner (
  input wire logic core_clk, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic reg_rd_req, // Read request
  input wire logic [15:0] reg_rd_addr, // Read address
  output logic reg_rd_ack, // Read answer strobe
  output logic [15:0] reg_rd_data, // Read value, garbage off the strobe
  input wire logic op_req, // Write request
  output logic op_done, // Write finished
  output logic op_range_err, // Value out of range
  input wire logic range_err_cmd, // Bench asks for a range fault
  output logic tx_ready // Transmitter accepts
);
  int seed = 32'he0ab2aaa;
  logic [31:0] r;
  // One answer per request; read data only holds its value with the strobe
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rd_ack <= 1'b0;
      reg_rd_data <= 16'h0000;
      op_done <= 1'b0;
      op_range_err <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      r = $random(seed);
      tx_ready <= r[0] | r[1];
      reg_rd_ack <= reg_rd_req && !reg_rd_ack && r[2];
      reg_rd_data <= (reg_rd_req && !reg_rd_ack && r[2]) ? reg_rd_addr ^ 16'h3c5a : r[31:16];
      op_done <= op_req && !op_done && r[3];
      op_range_err <= range_err_cmd;
    end
  end
endmodule
`default_nettype wire

// *** testbench/mrs_slave_resp_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module mrs_slave_resp_bench;
  import mrs_pkg::*;
  logic core_clk = 0, arst_n = 0, rx_valid = 0, rx_parity_bit = 0, rx_stop_bit = 1;
  logic frame_end = 0, ui_session_active = 0, nv_processing = 0, internal_busy_flag = 0;
  logic nv_alarm = 0, cmd_exec_disable = 0, rng_err = 0;
  logic [7:0] rx_data = 8'h00, cfg_slave_addr = 8'h11;
  logic [1:0] cfg_parity = 2'h1;
  logic op_req, op_bcast, op_done, op_range_err, reg_rd_req, reg_rd_ack, tx_valid, tx_ready;
  logic comm_err_valid, logv, opv;
  logic [40:0] opw;
  logic [7:0] op_func, tx_data, comm_err_code, logc;
  logic [15:0] op_addr, op_value, reg_rd_addr, reg_rd_data;
  logic [7:0] q[$], e[$], got[$];
  int n_errors = 0, checked = 0, seed = 32'he0ab2aaa;
  // Flags, function, word1, word2, exception code, logged code
  logic [61:0] tbl [12] = '{{6'h00, 8'h05, 16'h0000, 16'h0001, 8'h01, 8'h88},
    {6'h00, 8'h08, 16'h0001, 16'h1234, 8'h01, 8'h88}, {6'h00, 8'h03, 16'h0400, 16'h0000, 8'h03, 8'h8c},
    {6'h00, 8'h03, 16'h0400, 16'h0011, 8'h03, 8'h8c}, {6'h00, 8'h03, 16'h1ff8, 16'h0008, 8'h02, 8'h00},
    {6'h00, 8'h06, 16'h2000, 16'h0001, 8'h02, 8'h00}, {6'h20, 8'h03, 16'h0400, 16'h0002, 8'h04, 8'h89},
    {6'h10, 8'h03, 16'h0400, 16'h0002, 8'h04, 8'h8a}, {6'h08, 8'h03, 16'h0400, 16'h0002, 8'h04, 8'h8a},
    {6'h04, 8'h03, 16'h0400, 16'h0002, 8'h04, 8'h8a}, {6'h02, 8'h06, 16'h0100, 16'h0005, 8'h04, 8'h8d},
    {6'h01, 8'h06, 16'h0100, 16'h0005, 8'h04, 8'h8c}};
  always #50 core_clk = ~core_clk;
  mrs_slave_resp dut (.core_clk, .arst_n, .rx_valid, .rx_data, .rx_parity_bit, .rx_stop_bit,
    .frame_end, .cfg_parity, .cfg_slave_addr, .ui_session_active, .nv_processing,
    .internal_busy_flag, .nv_alarm, .cmd_exec_disable, .op_req, .op_func, .op_addr, .op_value,
    .op_bcast, .op_done, .op_range_err, .reg_rd_req, .reg_rd_addr, .reg_rd_ack, .reg_rd_data,
    .tx_valid, .tx_data, .tx_ready, .comm_err_valid, .comm_err_code);
  mrs_partner far_end (.core_clk, .arst_n, .reg_rd_req, .reg_rd_addr, .reg_rd_ack, .reg_rd_data,
    .op_req, .op_done, .op_range_err, .range_err_cmd(rng_err), .tx_ready);
  // Collects reply bytes, logged codes and write requests
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
    if (comm_err_valid === 1'b1) begin
      logv = 1;
      logc = comm_err_code;
    end
    if (op_req === 1'b1) begin
      opv = 1;
      opw = {op_bcast, op_func, op_addr, op_value};
    end
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [15:0] rdval(input logic [15:0] a);
    return a ^ 16'h3c5a;
  endfunction
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp8(input string nm, input logic [7:0] x, input logic [7:0] y);
    checked++;
    if (x !== y) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic cmpn(input string nm, input int x, input int y);
    checked++;
    if (x != y) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, x, y);
    end
  endtask
  task automatic mk(input logic [7:0] a, f, input logic [15:0] w1, w2);
    q = {a, f, w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
  endtask
  // Fault 1 stop bit, 2 parity, 3 check field
  task automatic send(input int fault);
    logic [15:0] c;
    c = crc16(q) ^ {16{fault == 3}};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(posedge core_clk);
      rx_valid <= 1;
      rx_data <= q[i];
      rx_stop_bit <= !(fault == 1 && i == 2);
      rx_parity_bit <= ^q[i] ^ (cfg_parity == 2'h2) ^ (fault == 2 && i == 3);
      frame_end <= (i == q.size() - 1);
    end
    @(posedge core_clk);
    rx_valid <= 0;
    frame_end <= 0;
  endtask
  task automatic go(input string nm, input int fault, input logic [7:0] lg, input logic ex);
    int quiet;
    logic [15:0] c;
    got = {};
    logv = 0;
    opv = 0;
    send(fault);
    c = crc16(e);
    if (e.size() > 0) e = {e, c[7:0], c[15:8]};
    quiet = 0;
    for (int k = 0; k < 3000 && quiet < 40; k++) begin
      @(posedge core_clk);
      quiet = (tx_valid === 1'b0) ? quiet + 1 : 0;
    end
    if (quiet < 40) begin
      cmpn({nm, " idle"}, 40, quiet);
      end_of_test();
    end
    cmpn({nm, " length"}, e.size(), got.size());
    foreach (e[i]) if (i < got.size()) cmp8(nm, e[i], got[i]);
    cmp8({nm, " log"}, lg, logv ? logc : 8'h00);
    cmp8({nm, " exec"}, {7'h00, ex}, {7'h00, opv});
    if (ex) begin
      cmp8({nm, " op func"}, q[1], opw[39:32]);
      cmp8({nm, " op addr hi"}, q[2], opw[31:24]);
      cmp8({nm, " op addr lo"}, q[3], opw[23:16]);
      cmp8({nm, " op value hi"}, q[4], opw[15:8]);
      cmp8({nm, " op value lo"}, q[5], opw[7:0]);
      cmp8({nm, " op bcast"}, {7'h00, q[0] == 8'h00}, {7'h00, opw[40]});
    end
    $display("TEST %s done", nm);
  endtask
  // Main sequence: reads, echo, write, exceptions, silent drops
  initial begin
    logic [15:0] a, v;
    int n;
    repeat (16) @(posedge core_clk);
    arst_n <= 1;
    @(posedge core_clk);
    for (int t = 0; t < 3; t++) begin
      a = 16'h0400 + 16'($random(seed) & 255);
      n = t ? 1 + ($random(seed) & 15) : 16;
      mk(8'h11, 8'h03, a, 16'(n));
      e = {8'h11, 8'h03, 8'(2 * n)};
      for (int i = 0; i < n; i++) begin
        v = rdval(a + 16'(i));
        e = {e, v[15:8], v[7:0]};
      end
      go("read", 0, 8'h00, 0);
    end
    mk(8'h11, 8'h08, 16'h0000, 16'($random(seed)));
    e = q;
    go("echo", 0, 8'h00, 0);
    mk(8'h11, 8'h06, 16'h024b, 16'h0050);
    e = q;
    go("write", 0, 8'h00, 1);
    foreach (tbl[k]) begin
      {ui_session_active, nv_processing, internal_busy_flag} <= tbl[k][61:59];
      {nv_alarm, cmd_exec_disable, rng_err} <= tbl[k][58:56];
      mk(8'h11, tbl[k][55:48], tbl[k][47:32], tbl[k][31:16]);
      e = {q[0], q[1] | 8'h80, tbl[k][15:8]};
      go("exception", 0, tbl[k][7:0], tbl[k][56]);
    end
    {ui_session_active, nv_processing, internal_busy_flag, nv_alarm, cmd_exec_disable} <= 5'h00;
    rng_err <= 0;
    for (int p = 1; p < 3; p++) begin
      cfg_parity <= 2'(p);
      for (int f = 1; f < 4; f++) begin
        mk(8'h11, 8'h03, 16'h0400, 16'h0002);
        e = {};
        go("drop", f, 8'h00, 0);
      end
    end
    mk(8'h12, 8'h03, 16'h0400, 16'h0002);
    go("foreign", 0, 8'h00, 0);
    mk(8'h00, 8'h03, 16'h0400, 16'h0002);
    go("bcast read", 0, 8'h00, 0);
    mk(8'h00, 8'h06, 16'h0100, 16'h1234);
    go("bcast write", 0, 8'h00, 1);
    q = {};
    repeat (257) q.push_back(8'($random(seed)));
    go("long", 0, 8'h00, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
